// ==== apd_block_decoder.sv ====
/*
 * Pass-through command block decoder. Collects a 16-byte command block,
 * checks tag and sub-opcode, then sequences taskfile accesses per mask,
 * honouring the action flags, and streams 12 readback bytes.
 * Assumes a taskfile access port that answers with tf_ack_in, and a
 * configuration memory supplying the tag byte and the drive-select byte.
 */
`timescale 1ns/1ps
module apd_block_decoder (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic cb_valid_in,
    input wire logic [7:0] cb_byte_in,
    input wire logic [7:0] cfg_tag_in,
    input wire logic [7:0] cfg_drive_in,
    input wire logic is_write_in,
    input wire logic tf_ack_in,
    input wire logic [7:0] tf_rdata_in,
    input wire logic drive_error_in,
    input wire logic phase_error_in,
    output logic passthru_out,
    output logic ordinary_out,
    output logic tf_req_out,
    output logic tf_we_out,
    output logic [9:0] tf_addr_out,
    output logic [7:0] tf_wdata_out,
    output logic rb_valid_out,
    output logic [7:0] rb_byte_out,
    output logic identify_out,
    output logic udma_out,
    output logic drive_sel_out,
    output logic readback_only_out,
    output logic halted_out,
    output logic done_out
);
    typedef enum logic [5:0] {
        APD_COLLECT = 6'b000001,
        APD_POLL = 6'b000010,
        APD_ACCESS = 6'b000100,
        APD_WAIT = 6'b001000,
        APD_RETURN = 6'b010000,
        APD_FINISH = 6'b100000
    } apd_state_t;

    apd_state_t state;
    apd_state_t next_state;
    logic [7:0] blk [apd_pkg::BLOCK_BYTES];
    logic [7:0] rb_data [8];
    logic [3:0] byte_cnt;
    logic [3:0] rb_cnt;
    logic last_q;
    logic poll_pend;
    apd_sel_if sel ();

    apd_mask_seq u_seq (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .sel(sel)
    );

    // Return byte order: position index into the readback stream.
    function automatic logic [7:0] rb_pick(input logic [3:0] pos,
                                           input logic [7:0] m,
                                           input logic [7:0] d [8]);
        logic [7:0] v;
        v = apd_pkg::ZERO_BYTE;
        if (pos < 4'h8 && m[pos[2:0]]) begin
            v = d[pos[2:0]];
        end
        return v;
    endfunction : rb_pick

    // Decode of the received block and of the action flags.
    wire [7:0] act = blk[apd_pkg::IDX_ACTION];
    wire [7:0] mask = blk[apd_pkg::IDX_MASK];
    wire last_byte = cb_valid_in && (byte_cnt == apd_pkg::IDX_LAST);
    wire tag_ok = blk[apd_pkg::IDX_TAG] == cfg_tag_in;
    wire sub_ok = blk[apd_pkg::IDX_SUB] == apd_pkg::SUB_OPCODE_EXT;
    wire sig_ok = tag_ok && sub_ok;
    wire readback = act[apd_pkg::ACT_READBACK];
    wire writing = is_write_in && !readback;
    wire busy_clear = !tf_rdata_in[apd_pkg::BSY_BIT];
    wire skip_alt = writing && (sel.index == 3'(apd_pkg::MASK_ALT_STATUS));
    wire do_access = sel.hit && !skip_alt;
    wire halt_now = (drive_error_in && !act[apd_pkg::ACT_DERR_CONT])
        || (phase_error_in && !act[apd_pkg::ACT_PERR_CONT]);
    wire drv_bit = act[apd_pkg::ACT_DRV_SRC] ? blk[4'h6 + 4'h5][apd_pkg::DEV_BIT]
                                             : cfg_drive_in[apd_pkg::DEV_BIT];
    wire [7:0] wdata = blk[4'h5 + {1'b0, sel.index}];
    wire [7:0] dh_data = {wdata[7:6], drv_bit, wdata[4:0]};

    assign sel.mask = mask;
    assign sel.start = (state == APD_COLLECT) && passthru_out;

    // Next state selection.
    always_comb begin
        next_state = state;
        unique case (state)
            APD_COLLECT: if (passthru_out) begin
                next_state = act[apd_pkg::ACT_SKIP_POLL] ? APD_ACCESS : APD_POLL;
            end
            APD_POLL: if (tf_ack_in && busy_clear) begin
                next_state = APD_ACCESS;
            end
            APD_ACCESS: if (halt_now) begin
                next_state = APD_FINISH;
            end else if (!sel.busy) begin
                next_state = readback ? APD_RETURN : APD_FINISH;
            end else if (do_access) begin
                next_state = APD_WAIT;
            end
            APD_WAIT: if (tf_ack_in) begin
                next_state = APD_ACCESS;
            end
            APD_RETURN: if (rb_cnt == 4'(apd_pkg::READBACK_BYTES - 1)) begin
                next_state = APD_FINISH;
            end
            APD_FINISH: next_state = APD_COLLECT;
        endcase
    end

    assign sel.advance = ((state == APD_ACCESS) && !do_access && !halt_now)
        || ((state == APD_WAIT) && tf_ack_in);

    // Block collection, taskfile requests and readback stream.
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state <= APD_COLLECT;
            poll_pend <= 1'b0;
            byte_cnt <= 4'h0;
            rb_cnt <= 4'h0;
            for (int i = 0; i < apd_pkg::BLOCK_BYTES; i++) blk[i] <= 8'h00;
            for (int i = 0; i < 8; i++) rb_data[i] <= 8'h00;
            passthru_out <= 1'b0;
            ordinary_out <= 1'b0;
            tf_req_out <= 1'b0;
            tf_we_out <= 1'b0;
            tf_addr_out <= 10'h000;
            tf_wdata_out <= 8'h00;
            rb_valid_out <= 1'b0;
            rb_byte_out <= 8'h00;
            identify_out <= 1'b0;
            udma_out <= 1'b0;
            drive_sel_out <= 1'b0;
            readback_only_out <= 1'b0;
            halted_out <= 1'b0;
            done_out <= 1'b0;
        end else begin
            state <= next_state;
            passthru_out <= 1'b0;
            ordinary_out <= 1'b0;
            done_out <= 1'b0;
            rb_valid_out <= 1'b0;
            tf_req_out <= 1'b0;
            if (state == APD_COLLECT && cb_valid_in) begin
                blk[byte_cnt] <= cb_byte_in;
                byte_cnt <= byte_cnt + 4'h1;
            end
            if (state == APD_COLLECT && byte_cnt == 4'h0 && last_q) begin
                passthru_out <= sig_ok;
                ordinary_out <= !sig_ok;
                identify_out <= act[apd_pkg::ACT_IDENTIFY];
                udma_out <= act[apd_pkg::ACT_UDMA];
                drive_sel_out <= drv_bit;
                readback_only_out <= readback;
                halted_out <= 1'b0;
                rb_cnt <= 4'h0;
            end
            if (state == APD_POLL) begin
                // One request per status read, so a slow drive never sees a held strobe.
                tf_req_out <= !poll_pend;
                poll_pend <= poll_pend ? !tf_ack_in : 1'b1;
                tf_we_out <= 1'b0;
                tf_addr_out <= apd_pkg::ALT_STATUS_ADDR;
            end
            if (state == APD_ACCESS && sel.busy && do_access && !halt_now) begin
                tf_req_out <= 1'b1;
                tf_we_out <= writing;
                tf_addr_out <= apd_pkg::TF_ADDR[sel.index];
                tf_wdata_out <= (sel.index == 3'h6) ? dh_data : wdata;
            end
            if (state == APD_WAIT && tf_ack_in && !writing) begin
                rb_data[sel.index] <= tf_rdata_in;
            end
            if (state == APD_ACCESS && halt_now) begin
                halted_out <= 1'b1;
            end
            if (state == APD_RETURN) begin
                rb_valid_out <= 1'b1;
                rb_byte_out <= rb_pick(rb_cnt, mask, rb_data);
                rb_cnt <= rb_cnt + 4'h1;
            end
            if (state == APD_FINISH) begin
                done_out <= 1'b1;
            end
        end
    end

    // Last-byte marker that arms the block verdict one cycle later.
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            last_q <= 1'b0;
        end else begin
            last_q <= last_byte;
        end
    end
endmodule : apd_block_decoder

// ==== apd_pkg.sv ====
/*
 * Package for the pass-through command block decoder: byte positions,
 * field positions, code values and taskfile ordering constants.
 * Assumes nothing of its surroundings.
 */
package apd_pkg;
    localparam int BLOCK_BYTES = 16;
    localparam int READBACK_BYTES = 12;
    localparam logic [7:0] SUB_OPCODE_EXT = 8'h25;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] IDENT_ATAPI_CMD = 8'hA1;
    localparam logic [7:0] IDENT_ATA_CMD = 8'hEC;
    localparam logic [3:0] IDX_TAG = 4'h0;
    localparam logic [3:0] IDX_SUB = 4'h1;
    localparam logic [3:0] IDX_MASK = 4'h2;
    localparam logic [3:0] IDX_ACTION = 4'h3;
    localparam logic [3:0] IDX_LAST = 4'hF;
    localparam int ACT_IDENTIFY = 7;
    localparam int ACT_UDMA = 6;
    localparam int ACT_DRV_SRC = 5;
    localparam int ACT_DERR_CONT = 4;
    localparam int ACT_PERR_CONT = 3;
    localparam int ACT_SKIP_POLL = 2;
    localparam int ACT_READBACK = 0;
    localparam int DEV_BIT = 5;
    localparam int BSY_BIT = 7;
    localparam int MASK_ALT_STATUS = 0;
    // Taskfile addresses in mask bit order 0 to 7.
    localparam logic [9:0] TF_ADDR [8] = '{10'h3F6, 10'h1F1, 10'h1F2, 10'h1F3,
                                           10'h1F4, 10'h1F5, 10'h1F6, 10'h1F7};
    localparam logic [9:0] ALT_STATUS_ADDR = 10'h3F6;
    localparam logic [2:0] SEL_FIRST = 3'h0;
    localparam logic [2:0] SEL_LAST = 3'h7;
endpackage : apd_pkg

// ==== apd_sel_if.sv ====
/*
 * Interface between the decoder top and its mask sequencer.
 * Assumes both ends share ref_clk_in.
 */
`timescale 1ns/1ps
interface apd_sel_if;
    logic start;
    logic [7:0] mask;
    logic advance;
    logic busy;
    logic hit;
    logic [2:0] index;
    modport top (output start, output mask, output advance,
                 input busy, input hit, input index);
    modport seq (input start, input mask, input advance,
                 output busy, output hit, output index);
endinterface : apd_sel_if

// ==== apd_mask_seq.sv ====
/*
 * Mask sequencer: walks the eight taskfile positions in ascending order
 * and reports whether the current position is selected.
 * Assumes start and advance are never asserted together.
 */
`timescale 1ns/1ps
module apd_mask_seq (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    apd_sel_if.seq sel
);
    logic [7:0] mask;
    logic [2:0] index;
    logic busy;

    // Continuous view of the current position for the top.
    assign sel.busy = busy;
    assign sel.index = index;
    assign sel.hit = mask[index];

    // Position counter steps from 0 to 7, then wraps to 0 and clears busy after 7.
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            mask <= 8'h00;
            index <= apd_pkg::SEL_FIRST;
            busy <= 1'b0;
        end else if (sel.start) begin
            mask <= sel.mask;
            index <= apd_pkg::SEL_FIRST;
            busy <= 1'b1;
        end else if (busy && sel.advance) begin
            index <= index + 3'h1;
            busy <= (index != apd_pkg::SEL_LAST);
        end
    end
endmodule : apd_mask_seq

// ==== apd_block_decoder_asserts.sv ====
/* Port assertions for the command block decoder.
   Bound to apd_block_decoder; one clock, reset async and high. */
`timescale 1ns/1ps
module apd_dec_chk (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic drive_error_in,
    input wire logic phase_error_in,
    input wire logic passthru_out,
    input wire logic ordinary_out,
    input wire logic tf_req_out,
    input wire logic tf_we_out,
    input wire logic [9:0] tf_addr_out,
    input wire logic rb_valid_out,
    input wire logic readback_only_out,
    input wire logic halted_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    // One-cycle beats of the request and the verdict pulse.
    sequence req_beat; tf_req_out ##1 !tf_req_out; endsequence
    sequence kind_beat; passthru_out ##1 !passthru_out; endsequence
    // Block kind, register map and pulse widths.
    block_kind_a: assert property (!(passthru_out && ordinary_out))
        else $error("block is both kinds");
    kind_pulse_a: assert property (passthru_out |-> kind_beat)
        else $error("verdict pulse too long");
    addr_map_a: assert property (tf_req_out |-> tf_addr_out inside {apd_pkg::TF_ADDR})
        else $error("unmapped taskfile address");
    alt_no_write_a: assert property (tf_req_out && tf_we_out |->
        tf_addr_out != apd_pkg::ALT_STATUS_ADDR)
        else $error("alternate status written");
    req_pulse_a: assert property (tf_req_out |-> req_beat)
        else $error("request longer than one cycle");
    rb_only_a: assert property (rb_valid_out |-> readback_only_out)
        else $error("readback outside readback mode");
    // Halting needs an error cause and stops further accesses.
    halt_cause_a: assert property ($rose(halted_out) |-> $past(drive_error_in || phase_error_in))
        else $error("halt without error");
    halt_quiet_a: assert property (halted_out |-> !tf_req_out)
        else $error("access while halted");
endmodule : apd_dec_chk
bind apd_block_decoder apd_dec_chk chk_i (.*);

// ==== apd_drive_model.sv ====
/* Behavioural drive on the taskfile port.
   Assumes requests are one-cycle pulses; inputs move at the falling edge. */
`timescale 1ns/1ps
module apd_drive_model (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic tf_req_out,
    input wire logic [9:0] tf_addr_out,
    output logic tf_ack_in,
    output logic [7:0] tf_rdata_in
);
    int wait_cnt = 0;
    bit slow = 1'b0;
    bit hold_busy = 1'b1;
    logic [9:0] addr_q = 10'h000;
    initial tf_ack_in = 1'b0;
    initial tf_rdata_in = 8'hFF;
    // Answers after one or three cycles in turn; data toggles outside the ack.
    // The very first status poll is answered busy, so the poll must repeat.
    always @(negedge ref_clk_in) begin
        if (sys_rst_in) begin
            wait_cnt = 0;
            tf_ack_in <= 1'b0;
            tf_rdata_in <= ~tf_rdata_in;
        end else if (wait_cnt == 1) begin
            wait_cnt = 0;
            tf_ack_in <= 1'b1;
            if (hold_busy && addr_q == apd_pkg::ALT_STATUS_ADDR) begin
                hold_busy = 1'b0;
                tf_rdata_in <= 8'h80;
            end else begin
                tf_rdata_in <= addr_q[7:0] ^ 8'h96;
            end
        end else begin
            tf_ack_in <= 1'b0;
            tf_rdata_in <= ~tf_rdata_in;
            if (wait_cnt > 1) begin
                wait_cnt--;
            end else if (tf_req_out === 1'b1) begin
                addr_q = tf_addr_out;
                slow = ~slow;
                wait_cnt = slow ? 3 : 1;
            end
        end
    end
endmodule : apd_drive_model

// ==== apd_block_decoder_test.sv ====
/* Self-checking bench for the command block decoder.
   Assumes the drive model and the port checker are compiled first. */
`timescale 1ns/1ps
module apd_block_decoder_test;
    logic ref_clk_in = 1'b0, sys_rst_in = 1'b1, cb_valid_in = 1'b0, is_write_in = 1'b0;
    logic drive_error_in = 1'b0, phase_error_in = 1'b0;
    logic [7:0] cb_byte_in = 8'h00, cfg_tag_in = 8'h9C, cfg_drive_in = 8'h20;
    logic [7:0] sub_err = 8'h00;
    logic tf_ack_in, tf_req_out, tf_we_out, passthru_out, ordinary_out, rb_valid_out;
    logic identify_out, udma_out, drive_sel_out, readback_only_out, halted_out, done_out;
    logic [7:0] tf_rdata_in, tf_wdata_out, rb_byte_out;
    logic [9:0] tf_addr_out;
    logic [18:0] acc_q[$];
    logic [7:0] rb_q[$];
    int fails = 0;
    int checks = 0;
    apd_block_decoder dut (.*);
    apd_drive_model drive (.*);
    // The clock runs at 250 MHz.
    always #2 ref_clk_in = ~ref_clk_in;
    // Logs accesses and readback bytes at the falling edge, once outputs settle.
    always @(negedge ref_clk_in) begin
        if (tf_req_out === 1'b1) acc_q.push_back({tf_we_out, tf_addr_out, tf_wdata_out & {8{tf_we_out}}});
        if (rb_valid_out === 1'b1) rb_q.push_back(rb_byte_out);
    end
    task automatic chk(input string what, input logic [18:0] exp, input logic [18:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    // Sends one 16-byte block; register data byte 5+i is 10h+i, bytes 4, 13..15 zero.
    task automatic send(input logic [7:0] tag, input logic [7:0] mask, input logic [7:0] act);
        logic [7:0] blk [16];
        blk = '{default: 8'h00};
        blk[0] = tag;
        blk[1] = apd_pkg::SUB_OPCODE_EXT ^ sub_err;
        blk[2] = mask;
        blk[3] = act;
        for (int i = 0; i < 8; i++) blk[5 + i] = 8'h10 + 8'(i);
        acc_q.delete();
        rb_q.delete();
        for (int i = 0; i < 16; i++) begin
            cb_valid_in = 1'b1;
            cb_byte_in = blk[i];
            @(negedge ref_clk_in);
        end
        cb_valid_in = 1'b0;
    endtask : send
    task automatic wait_end();
        int n;
        n = 0;
        // Let the verdict edge pass so a halt left from the last block is cleared.
        repeat (2) @(negedge ref_clk_in);
        while (done_out !== 1'b1 && halted_out !== 1'b1 && n < 400) begin
            @(negedge ref_clk_in);
            n++;
        end
        chk("end seen", 19'd1, 19'(n < 400));
        repeat (2) @(negedge ref_clk_in);
    endtask : wait_end
    task automatic t_tag();
        logic sp, so;
        for (int k = 2; k >= 0; k--) begin
            sp = 1'b0;
            so = 1'b0;
            sub_err = 8'(k == 2);
            send(cfg_tag_in ^ 8'(k == 1), 8'h00, 8'h05);
            repeat (4) begin
                sp = sp | (passthru_out === 1'b1);
                so = so | (ordinary_out === 1'b1);
                @(negedge ref_clk_in);
            end
            chk("passthru", 19'(k == 0), 19'(sp));
            chk("ordinary", 19'(k != 0), 19'(so));
        end
        wait_end();
        $display("tag test done");
    endtask : t_tag
    task automatic t_rb(input logic [7:0] mask, input logic [7:0] act);
        int n;
        n = 0;
        send(cfg_tag_in, mask, act);
        wait_end();
        if (!act[2]) begin
            for (int p = 0; p < 2; p++) begin
                chk("busy poll", {1'b0, apd_pkg::ALT_STATUS_ADDR, 8'h00}, acc_q[p]);
            end
            n = 2;
        end
        chk("rb count", 19'd12, 19'(rb_q.size()));
        for (int i = 0; i < 12; i++) begin
            chk("rb byte", (i < 8 && mask[i]) ? 19'(apd_pkg::TF_ADDR[i][7:0] ^ 8'h96) : 19'h0,
                19'(rb_q[i]));
            if (i < 8 && mask[i]) begin
                chk("access", {1'b0, apd_pkg::TF_ADDR[i], 8'h00}, acc_q[n]);
                n++;
            end
        end
        chk("access count", 19'(n), 19'(acc_q.size()));
        chk("readback flag", 19'd1, 19'(readback_only_out));
        $display("readback test done");
    endtask : t_rb
    task automatic t_flags();
        logic [7:0] act;
        for (int k = 0; k < 2; k++) begin
            act = k ? 8'hE4 : 8'h04;
            send(cfg_tag_in, 8'h00, act);
            wait_end();
            chk("identify", 19'(act[7]), 19'(identify_out));
            chk("udma", 19'(act[6]), 19'(udma_out));
            chk("drive sel", 19'(act[5] ? 1'b0 : cfg_drive_in[5]), 19'(drive_sel_out));
        end
        $display("flag test done");
    endtask : t_flags
    task automatic t_write();
        is_write_in = 1'b1;
        send(cfg_tag_in, 8'hFF, 8'h24);
        wait_end();
        chk("write count", 19'd7, 19'(acc_q.size()));
        for (int i = 1; i < 8; i++) begin
            chk("write", {1'b1, apd_pkg::TF_ADDR[i], 8'h10 + 8'(i)}, acc_q[i - 1]);
        end
        is_write_in = 1'b0;
        $display("write test done");
    endtask : t_write
    task automatic t_err();
        phase_error_in = 1'b1;
        send(cfg_tag_in, 8'hFF, 8'h0C);
        wait_end();
        chk("phase continue", 19'd0, 19'(halted_out));
        send(cfg_tag_in, 8'hFF, 8'h04);
        wait_end();
        chk("phase halt", 19'd1, 19'(halted_out));
        phase_error_in = 1'b0;
        drive_error_in = 1'b1;
        send(cfg_tag_in, 8'hFF, 8'h14);
        wait_end();
        chk("drive continue", 19'd0, 19'(halted_out));
        send(cfg_tag_in, 8'hFF, 8'h04);
        wait_end();
        chk("drive halt", 19'd1, 19'(halted_out));
        drive_error_in = 1'b0;
        $display("error test done");
    endtask : t_err
    task automatic stop_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    // Main sequence: reset for four cycles, then each test in turn.
    initial begin
        repeat (4) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        sys_rst_in = 1'b0;
        t_tag();
        t_rb(8'h00, 8'h05);
        t_rb(8'hA5, 8'h01);
        t_flags();
        t_write();
        t_err();
        stop_test();
    end
    // Watchdog well beyond the few hundred cycles the tests need.
    initial begin
        #40000;
        fails++;
        stop_test();
    end
endmodule : apd_block_decoder_test
